// ===== hdl/tqd_pkg.sv
// Purpose: shared constants of the three-axis quadrature decoder
// Assumes: 16-bit register data, printed byte offsets used as addresses
// Notes: offsets, field positions, reset values and widths live here
package tqd_pkg;
    // register offsets
    localparam logic [31:0] TQD_OFS_CTRL = 32'h5000_0200;
    localparam logic [31:0] TQD_OFS_XCNT = 32'h5000_0202;
    localparam logic [31:0] TQD_OFS_YCNT = 32'h5000_0204;
    localparam logic [31:0] TQD_OFS_DIV = 32'h5000_0206;
    localparam logic [31:0] TQD_OFS_SEL = 32'h5000_0208;
    localparam logic [31:0] TQD_OFS_ZCNT = 32'h5000_020A;
    localparam logic [31:0] TQD_OFS_EVT_STAT = 32'h5000_020C;
    localparam logic [31:0] TQD_OFS_EVT_CLR = 32'h5000_020E;
    localparam logic [31:0] TQD_OFS_EVT_EN = 32'h5000_0210;
    // widths
    localparam int TQD_DATA_W = 16;
    localparam int TQD_CNT_W = 16;
    localparam int TQD_THR_W = 7;
    localparam int TQD_DIV_W = 10;
    localparam int TQD_SEL_W = 4;
    localparam int TQD_EVT_W = 4;
    localparam int TQD_AXES = 3;
    // control register fields
    localparam int TQD_CTRL_MASK_BIT = 0;
    localparam int TQD_CTRL_CLR_BIT = 1;
    localparam int TQD_CTRL_STAT_BIT = 2;
    localparam int TQD_CTRL_THR_LSB = 3;
    // pin selection fields, one nibble per axis from x upward
    localparam int TQD_SEL_X_LSB = 0;
    localparam int TQD_SEL_Y_LSB = 4;
    localparam int TQD_SEL_Z_LSB = 8;
    // event status bits
    localparam int TQD_EVT_THR_BIT = 0;
    localparam int TQD_EVT_WRAP_LSB = 1;
    // reset values and limits
    localparam logic [6:0] TQD_THR_RST = 7'h02;
    localparam logic [6:0] TQD_THR_MIN = 7'h01;
    localparam logic [6:0] TQD_TALLY_MAX = 7'h7F;
    localparam logic [9:0] TQD_DIV_RST = 10'h000;
    localparam logic [11:0] TQD_SEL_RST = 12'h000;
    localparam logic [15:0] TQD_CNT_RST = 16'h0000;
    localparam logic [15:0] TQD_CNT_POS_MAX = 16'h7FFF;
    localparam logic [15:0] TQD_CNT_NEG_MAX = 16'h8000;
    // pin pair codes
    localparam logic [3:0] TQD_PAIR_FIRST = 4'h1;
    localparam logic [3:0] TQD_PAIR_LAST = 4'hA;
endpackage

// ===== hdl/tqd_decoder.sv
// Purpose: three-axis quadrature decoder with register port and interrupt
// Assumes: one clock, synchronous active-low reset, pins asynchronous
// Notes: counters run on the divided logic tick, registers on every clock
//        a phase must stand for a whole logic cycle to count reliably
//        event status and enable widen the interrupt beyond the threshold
//        all registers sit on one clock; only the pins are synchronised
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - the pending interrupt sets once events on any axis reach the 7-bit threshold, reset 2.
// - a threshold of zero acts as a threshold of one.
// - control bit 2 reads one once the interrupt condition has occurred.
// - writing one to the clear bit clears the pending interrupt and the bit reads back zero.
// - the mask bit, zero after reset, gates the pending interrupt onto the line.
// - each axis keeps a signed 16-bit read-only event counter.
// - an axis with no pin pair selected holds its counter at zero.
// - a 10-bit divider gives one logic tick every divider plus one clock cycles.
// - the x nibble of the selection register picks the x pins, zero disables x.
// - the y nibble of the selection register picks the y pins, zero disables y.
// - the z nibble of the selection register picks the z pins, zero disables z.
// - codes 1-10 pick fixed port pin pairs for phases a and b, codes 11-15 pick none.
module tqd_decoder (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [31:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic [7:0] p0_pins_in,
    input wire logic [5:0] p1_pins_in,
    input wire logic [9:0] p2_pins_in,
    output logic irq_out
);

    // control register fields
    logic [6:0] event_threshold_r;
    logic irq_enable_bit_r;
    logic irq_pending_flag_r;

    // configuration registers
    logic [9:0] div_r;
    logic [11:0] pin_sel_r;

    // event status, enable and the registered outputs
    logic [3:0] evt_stat_r;
    logic [3:0] evt_en_r;
    logic [15:0] rdata_r;
    logic irq_r;

    // pin synchronisers
    logic [23:0] pin_meta_r;
    logic [23:0] pin_sync_r;

    // divider
    logic [9:0] div_cnt_r;
    logic tick;

    // per-axis results gathered for the register port
    wire logic [47:0] cnt_bus;
    wire logic [2:0] reach_bus;
    wire logic [2:0] wrap_bus;

    // decoded bus strobes
    logic wr_ctrl;
    logic wr_div;
    logic wr_sel;
    logic wr_evt_clr;
    logic wr_evt_en;
    logic irq_clear_strobe;

    // derived threshold and event terms
    logic [6:0] thr_eff;
    logic [3:0] evt_set;
    logic [3:0] evt_clr_mask;

    // pin pair lookup: returns {phase a, phase b}
    function automatic logic [1:0] pair_pick(
        input logic [3:0] sel,
        input logic [23:0] pins
    );
        logic [7:0] p0;
        logic [5:0] p1;
        logic [9:0] p2;
        // port0 in the low byte, port1 next, port2 on top
        p0 = pins[7:0];
        p1 = pins[13:8];
        p2 = pins[23:14];
        case (sel)
            // port0 pairs
            4'h1: pair_pick = {p0[0], p0[1]};
            4'h2: pair_pick = {p0[2], p0[3]};
            4'h3: pair_pick = {p0[4], p0[5]};
            4'h4: pair_pick = {p0[6], p0[7]};
            // port1 pairs
            4'h5: pair_pick = {p1[0], p1[1]};
            4'h6: pair_pick = {p1[2], p1[3]};
            // port2 pairs, the last one wraps to pin 0
            4'h7: pair_pick = {p2[3], p2[4]};
            4'h8: pair_pick = {p2[5], p2[6]};
            4'h9: pair_pick = {p2[7], p2[8]};
            4'hA: pair_pick = {p2[9], p2[0]};
            // zero and codes 11-15 pick no pins
            default: pair_pick = 2'b00;
        endcase
    endfunction

    // two-stage synchroniser for every port pin
    // the pins change at any time, so the first stage may go metastable;
    // only the second stage is read by the decoders
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            pin_meta_r <= 24'h000000;
            pin_sync_r <= 24'h000000;
        end else begin
            pin_meta_r <= {p2_pins_in, p1_pins_in, p0_pins_in};
            pin_sync_r <= pin_meta_r;
        end
    end

    // register write decode
    assign wr_ctrl = reg_wr_in && (reg_addr_in == tqd_pkg::TQD_OFS_CTRL);
    assign wr_div = reg_wr_in && (reg_addr_in == tqd_pkg::TQD_OFS_DIV);
    assign wr_sel = reg_wr_in && (reg_addr_in == tqd_pkg::TQD_OFS_SEL);
    assign wr_evt_clr = reg_wr_in && (reg_addr_in == tqd_pkg::TQD_OFS_EVT_CLR);
    assign wr_evt_en = reg_wr_in && (reg_addr_in == tqd_pkg::TQD_OFS_EVT_EN);
    // writes to read-only and unmapped offsets match none of these

    // the clear bit is a strobe only and is never stored
    // clear strobe
    assign irq_clear_strobe = wr_ctrl && reg_wdata_in[tqd_pkg::TQD_CTRL_CLR_BIT];

    assign thr_eff = (event_threshold_r == 7'h00) ? tqd_pkg::TQD_THR_MIN : event_threshold_r;

    // control register: threshold and mask, clear bit is not stored
    // a write always rewrites threshold and mask together
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            event_threshold_r <= tqd_pkg::TQD_THR_RST;
            irq_enable_bit_r <= 1'b0;
        end else if (wr_ctrl) begin
            event_threshold_r <= reg_wdata_in[tqd_pkg::TQD_CTRL_THR_LSB +: 7];
            irq_enable_bit_r <= reg_wdata_in[tqd_pkg::TQD_CTRL_MASK_BIT];
        end
    end

    // divider and pin selection registers
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            div_r <= tqd_pkg::TQD_DIV_RST;
            pin_sel_r <= tqd_pkg::TQD_SEL_RST;
        end else begin
            if (wr_div) begin
                div_r <= reg_wdata_in[9:0];
            end
            if (wr_sel) begin
                pin_sel_r <= reg_wdata_in[11:0];
            end
        end
    end

    // count from zero up to the divider value, then start again;
    // a divider of zero ticks on every clock
    // logic tick divider
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            div_cnt_r <= 10'h000;
        end else if (div_cnt_r >= div_r) begin
            div_cnt_r <= 10'h000; // also catches a divider lowered mid-count
        end else begin
            div_cnt_r <= div_cnt_r + 10'h001;
        end
    end

    // tick stands in the last clock of each logic cycle
    assign tick = (div_cnt_r >= div_r);

    // one decoder per axis: x, y, z
    for (genvar i = 0; i < tqd_pkg::TQD_AXES; i++) begin : g_axis
        // pin choice and phases
        logic [3:0] sel;
        logic en;
        logic [1:0] ab;
        logic [1:0] ab_prev_r;
        logic [3:0] sel_seen_r;

        // count and tally
        logic [15:0] cnt_r;
        logic [6:0] tally_r;
        logic [6:0] tally_base;
        logic [6:0] tally_p1;

        // step decode
        logic step_ok;
        logic step_up;

        assign sel = pin_sel_r[i * 4 +: 4];
        // codes outside 1-10 disable the axis
        // pin pair codes
        assign en = (sel >= tqd_pkg::TQD_PAIR_FIRST) && (sel <= tqd_pkg::TQD_PAIR_LAST);
        // phases as {a, b} from the synchronised pins
        assign ab = pair_pick(sel, pin_sync_r);

        // a valid step changes exactly one phase since the last tick;
        // both phases changing at once is a lost step and is ignored
        // one-phase step
        assign step_ok = en && tick && (sel == sel_seen_r)
            && (((ab[1] ^ ab_prev_r[1]) ^ (ab[0] ^ ab_prev_r[0])) == 1'b1);
        // up when the new a differs from the old b
        assign step_up = ab[1] ^ ab_prev_r[0]; // a leading b counts up

        // without the reload a change of pins would look like a step
        // previous phases, reloaded on a new pin choice so it never counts
        always_ff @(posedge clk_sys_in) begin
            if (!rst_n_in) begin
                ab_prev_r <= 2'b00;
                sel_seen_r <= 4'h0;
            end else if (tick || (sel != sel_seen_r)) begin
                ab_prev_r <= ab;
                sel_seen_r <= sel;
            end
        end

        // the counter wraps silently; the wrap is flagged below
        // signed counter
        always_ff @(posedge clk_sys_in) begin
            if (!rst_n_in || !en) begin
                cnt_r <= tqd_pkg::TQD_CNT_RST;
            end else if (step_ok && step_up) begin
                cnt_r <= cnt_r + 16'h0001;
            end else if (step_ok) begin
                cnt_r <= cnt_r - 16'h0001;
            end
        end

        // events since the last interrupt clear; a step in the clear cycle survives
        assign tally_base = irq_clear_strobe ? 7'h00 : tally_r;
        // saturate so a long run never wraps back below the threshold
        assign tally_p1 = (tally_base == tqd_pkg::TQD_TALLY_MAX) ? tally_base
            : tally_base + 7'h01;

        // tally counts steps of either direction since the last clear;
        // a disabled axis forgets its tally
        always_ff @(posedge clk_sys_in) begin
            if (!rst_n_in || !en) begin
                tally_r <= 7'h00;
            end else if (step_ok) begin
                tally_r <= tally_p1;
            end else begin
                tally_r <= tally_base;
            end
        end

        // the step that lifts the tally to the threshold raises the event
        // threshold reached
        assign reach_bus[i] = step_ok && (tally_p1 >= thr_eff);
        // counter wraps past its signed range, flagged so software
        // can extend the count beyond 16 bits
        assign wrap_bus[i] = step_ok
            && ((step_up && (cnt_r == tqd_pkg::TQD_CNT_POS_MAX))
            || (!step_up && (cnt_r == tqd_pkg::TQD_CNT_NEG_MAX)));
        // counters gathered for the read mux
        assign cnt_bus[i * 16 +: 16] = cnt_r;
    end

    // the flag stays set until a clear with no event beside it;
    // the mask gates only the line further down
    // pending flag, a new event wins over a clear
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            irq_pending_flag_r <= 1'b0;
        end else if (|reach_bus) begin
            irq_pending_flag_r <= 1'b1;
        end else if (irq_clear_strobe) begin
            irq_pending_flag_r <= 1'b0;
        end
    end

    // sticky event status: threshold and the three wraps
    assign evt_set = {wrap_bus, |reach_bus};
    // a write to the clear register drops the bits written as one
    assign evt_clr_mask = wr_evt_clr ? reg_wdata_in[3:0] : 4'h0;

    // status bits set by hardware and cleared by software
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            evt_stat_r <= 4'h0;
        end else begin
            evt_stat_r <= (evt_stat_r & ~evt_clr_mask) | evt_set; // set wins
        end
    end

    // event enable register
    // only the low four bits exist; the rest read zero
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            evt_en_r <= 4'h0;
        end else if (wr_evt_en) begin
            evt_en_r <= reg_wdata_in[3:0];
        end
    end

    // either the masked threshold flag or any enabled status bit;
    // registered so the line never glitches while the terms settle
    // masked interrupt line
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (irq_pending_flag_r && irq_enable_bit_r) || (|(evt_stat_r & evt_en_r));
        end
    end

    // read data, valid only in the cycle after the read strobe
    // a low strobe forces zero, so the port reads zero when idle
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !reg_rd_in) begin
            rdata_r <= 16'h0000;
        end else begin
            case (reg_addr_in)
                // status bit, clear bit reads zero
                tqd_pkg::TQD_OFS_CTRL: rdata_r <= {6'h00, event_threshold_r,
                    irq_pending_flag_r, 1'b0, irq_enable_bit_r};
                // axis counters, signed
                tqd_pkg::TQD_OFS_XCNT: rdata_r <= cnt_bus[15:0];
                tqd_pkg::TQD_OFS_YCNT: rdata_r <= cnt_bus[31:16];
                tqd_pkg::TQD_OFS_ZCNT: rdata_r <= cnt_bus[47:32];
                // configuration registers
                tqd_pkg::TQD_OFS_DIV: rdata_r <= {6'h00, div_r};
                tqd_pkg::TQD_OFS_SEL: rdata_r <= {4'h0, pin_sel_r};
                // event status and enable; the clear register reads zero
                tqd_pkg::TQD_OFS_EVT_STAT: rdata_r <= {12'h000, evt_stat_r};
                tqd_pkg::TQD_OFS_EVT_EN: rdata_r <= {12'h000, evt_en_r};
                default: rdata_r <= 16'h0000; // unmapped and write-only
            endcase
        end
    end

    // outputs come straight from their registers
    assign reg_rdata_out = rdata_r;
    assign irq_out = irq_r;

endmodule

`default_nettype wire

// ===== tb/tqd_enc_model.sv
// Purpose: quadrature encoder standing on the general purpose pins
// Assumes: one step request per pulse, never up and down together
// Notes: phase order 00,10,11,01 when turning up, reversed when down
`timescale 1ns/100ps
`default_nettype none
module tqd_enc_model (
    input wire logic clk_in,
    input wire logic up_in,
    input wire logic dn_in,
    output logic a_out,
    output logic b_out
);
    logic [1:0] ph_r = 2'h0;
    always_ff @(posedge clk_in) begin
        if (up_in) ph_r <= ph_r + 2'h1;
        else if (dn_in) ph_r <= ph_r - 2'h1;
    end
    // gray mapping, a leads b when turning up
    assign a_out = ph_r[1] ^ ph_r[0];
    assign b_out = ph_r[1];
endmodule
`default_nettype wire

// ===== tb/tqd_decoder_chk.sv
// Purpose: port-level checks of the quadrature decoder
// Assumes: sees only the top module ports
// Notes: read data belongs to the cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
module tqd_decoder_chk (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [31:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic [7:0] p0_pins_in,
    input wire logic [5:0] p1_pins_in,
    input wire logic [9:0] p2_pins_in,
    input wire logic irq_out
);
    logic wrote_r;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // remembers any write since reset
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) wrote_r <= 1'b0;
        else if (reg_wr_in) wrote_r <= 1'b1;
    end
    idle_rdata_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data not zero outside read");
    unmapped_read_a: assert property ($past(reg_rd_in)
        && $past(reg_addr_in) > tqd_pkg::TQD_OFS_EVT_EN |-> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    clear_bit_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == tqd_pkg::TQD_OFS_CTRL
        |-> !reg_rdata_out[1] && reg_rdata_out[15:10] == 6'h00)
        else $error("control clear bit reads one");
    thr_reset_a: assert property ($past(reg_rd_in) && !wrote_r
        && $past(reg_addr_in) == tqd_pkg::TQD_OFS_CTRL |-> reg_rdata_out == 16'h0010)
        else $error("control reset value wrong");
    div_field_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == tqd_pkg::TQD_OFS_DIV
        |-> reg_rdata_out[15:10] == 6'h00)
        else $error("divider upper bits set");
    sel_field_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == tqd_pkg::TQD_OFS_SEL
        |-> reg_rdata_out[15:12] == 4'h0)
        else $error("selection upper bits set");
    reset_quiet_a: assert property ($rose(rst_n_in) |-> !irq_out && reg_rdata_out == 16'h0000)
        else $error("outputs busy after reset");
    irq_masked_a: assert property (irq_out |-> wrote_r)
        else $error("interrupt without any enable");
    cover property ($rose(irq_out));
    cover property ($past(reg_rd_in) && $past(reg_addr_in) == tqd_pkg::TQD_OFS_CTRL
        && reg_rdata_out[2]);
    cover property ($past(reg_rd_in) && $past(reg_addr_in) == tqd_pkg::TQD_OFS_ZCNT
        && reg_rdata_out == 16'h0002);
endmodule
bind tqd_decoder tqd_decoder_chk chk (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .p0_pins_in(p0_pins_in),
    .p1_pins_in(p1_pins_in), .p2_pins_in(p2_pins_in), .irq_out(irq_out));
`default_nettype wire

// ===== tb/test_three_axis_quadrature_decoder.sv
// Purpose: register level tests of the quadrature decoder
// Assumes: divider 3 in the pin tests, so a step counts within a few clocks
// Notes: pins outside the chosen pair toggle together every clock
`timescale 1ns/100ps
`default_nettype none
module test_three_axis_quadrature_decoder;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [31:0] reg_addr_in = 32'h0;
    logic [15:0] reg_wdata_in = 16'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [15:0] reg_rdata_out;
    logic irq_out;
    logic [23:0] pins;
    logic [23:0] noise = 24'h0;
    logic up = 1'b0;
    logic dn = 1'b0;
    logic enc_a;
    logic enc_b;
    int ia = 0;
    int ib = 1;
    int num_errors = 0;
    int checked = 0;
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // encoder on the chosen pair, noise elsewhere
    always @(posedge clk_sys_in) noise <= ~noise;
    always_comb begin
        pins = noise;
        pins[ia] = enc_a;
        pins[ib] = enc_b;
    end
    tqd_enc_model enc (.clk_in(clk_sys_in), .up_in(up), .dn_in(dn), .a_out(enc_a), .b_out(enc_b));
    tqd_decoder dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .p0_pins_in(pins[7:0]), .p1_pins_in(pins[13:8]),
        .p2_pins_in(pins[23:14]), .irq_out(irq_out));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] e, input string n);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 chk(n, e, reg_rdata_out);
    endtask
    // one-cycle step pulses, spaced to cover sync and tick
    task automatic step(input logic u, input int n);
        repeat (n) begin
            @(posedge clk_sys_in);
            up <= u;
            dn <= !u;
            @(posedge clk_sys_in);
            up <= 1'b0;
            dn <= 1'b0;
            repeat (10) @(posedge clk_sys_in);
        end
    endtask
    initial begin
        #400000;
        num_errors++;
        stop_test();
    end
    initial begin
        logic [31:0] ca;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd(tqd_pkg::TQD_OFS_CTRL, 16'h0010, "ctrl");
        rd(tqd_pkg::TQD_OFS_XCNT, 16'h0000, "xcnt");
        rd(tqd_pkg::TQD_OFS_YCNT, 16'h0000, "ycnt");
        rd(tqd_pkg::TQD_OFS_ZCNT, 16'h0000, "zcnt");
        rd(tqd_pkg::TQD_OFS_DIV, 16'h0000, "div");
        rd(tqd_pkg::TQD_OFS_SEL, 16'h0000, "sel");
        rd(tqd_pkg::TQD_OFS_EVT_STAT, 16'h0000, "evt");
        rd(32'h5000_0212, 16'h0000, "unmapped");
        wr(tqd_pkg::TQD_OFS_XCNT, 16'hFFFF);
        rd(tqd_pkg::TQD_OFS_XCNT, 16'h0000, "xcnt ro");
        wr(tqd_pkg::TQD_OFS_DIV, 16'hFFFF);
        rd(tqd_pkg::TQD_OFS_DIV, 16'h03FF, "div");
        wr(tqd_pkg::TQD_OFS_EVT_EN, 16'hFFFF);
        rd(tqd_pkg::TQD_OFS_EVT_EN, 16'h000F, "evt en");
        wr(tqd_pkg::TQD_OFS_EVT_EN, 16'h0000);
        wr(tqd_pkg::TQD_OFS_DIV, 16'h0003);
        $display("test registers done");
        for (int ax = 0; ax < 3; ax++) begin
            ca = (ax == 2) ? tqd_pkg::TQD_OFS_ZCNT : tqd_pkg::TQD_OFS_XCNT + 32'(2 * ax);
            for (int c = 1; c < 16; c++) begin
                wr(tqd_pkg::TQD_OFS_SEL, 16'h0000);
                rd(ca, 16'h0000, "count off");
                ia = (c > 10) ? 0 : (c < 7) ? 2 * c - 2 : 2 * c + 3;
                ib = (c == 10) ? 14 : ia + 1;
                wr(tqd_pkg::TQD_OFS_SEL, 16'(c) << (4 * ax));
                rd(tqd_pkg::TQD_OFS_SEL, 16'(c) << (4 * ax), "sel");
                repeat (4) @(posedge clk_sys_in);
                step(1'b1, 3);
                step(1'b0, 1);
                rd(ca, (c < 11) ? 16'h0002 : 16'h0000, "count");
            end
        end
        $display("test pin pairs done");
        wr(tqd_pkg::TQD_OFS_SEL, 16'h0000);
        ia = 0;
        ib = 1;
        wr(tqd_pkg::TQD_OFS_SEL, 16'h0001);
        repeat (4) @(posedge clk_sys_in);
        wr(tqd_pkg::TQD_OFS_CTRL, 16'h0012);
        step(1'b0, 1);
        rd(tqd_pkg::TQD_OFS_CTRL, 16'h0010, "ctrl one");
        step(1'b0, 1);
        rd(tqd_pkg::TQD_OFS_CTRL, 16'h0014, "ctrl two");
        chk("irq masked", 16'h0000, {15'h0, irq_out});
        wr(tqd_pkg::TQD_OFS_CTRL, 16'h0011);
        rd(tqd_pkg::TQD_OFS_CTRL, 16'h0015, "ctrl mask");
        chk("irq on", 16'h0001, {15'h0, irq_out});
        wr(tqd_pkg::TQD_OFS_CTRL, 16'h0013);
        rd(tqd_pkg::TQD_OFS_CTRL, 16'h0011, "ctrl clr");
        chk("irq clr", 16'h0000, {15'h0, irq_out});
        wr(tqd_pkg::TQD_OFS_CTRL, 16'h0003);
        step(1'b0, 1);
        rd(tqd_pkg::TQD_OFS_CTRL, 16'h0005, "ctrl zero");
        chk("irq zero", 16'h0001, {15'h0, irq_out});
        rd(tqd_pkg::TQD_OFS_XCNT, 16'hFFFD, "xcnt neg");
        $display("test interrupt done");
        rd(tqd_pkg::TQD_OFS_EVT_STAT, 16'h0001, "evt thr");
        wr(tqd_pkg::TQD_OFS_CTRL, 16'h0002);
        rd(tqd_pkg::TQD_OFS_CTRL, 16'h0000, "ctrl off");
        chk("irq off", 16'h0000, {15'h0, irq_out});
        wr(tqd_pkg::TQD_OFS_EVT_EN, 16'h0001);
        rd(tqd_pkg::TQD_OFS_EVT_STAT, 16'h0001, "evt kept");
        chk("irq evt", 16'h0001, {15'h0, irq_out});
        wr(tqd_pkg::TQD_OFS_EVT_CLR, 16'h000F);
        rd(tqd_pkg::TQD_OFS_EVT_STAT, 16'h0000, "evt clr");
        rd(tqd_pkg::TQD_OFS_EVT_CLR, 16'h0000, "evt clr reads");
        chk("irq evt clr", 16'h0000, {15'h0, irq_out});
        $display("test event status done");
        wr(tqd_pkg::TQD_OFS_DIV, 16'h0000);
        wr(tqd_pkg::TQD_OFS_DIV, 16'h03FF);
        step(1'b1, 1);
        rd(tqd_pkg::TQD_OFS_XCNT, 16'hFFFD, "xcnt before tick");
        repeat (1030) @(posedge clk_sys_in);
        rd(tqd_pkg::TQD_OFS_XCNT, 16'hFFFE, "xcnt after tick");
        rd(tqd_pkg::TQD_OFS_EVT_STAT, 16'h0001, "evt again");
        chk("irq evt again", 16'h0001, {15'h0, irq_out});
        $display("test divider done");
        stop_test();
    end
endmodule
`default_nettype wire
